/* File: igm_pkg.sv */
// Package with register map, field layout and reset values of the input gain and power monitor block.
package igm_pkg;
  localparam logic [3:0]  ADDR_GAIN_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_DWELL         = 4'h1;
  localparam logic [3:0]  ADDR_PERIOD        = 4'h2;
  localparam logic [3:0]  ADDR_RESULT        = 4'h3;
  localparam logic [3:0]  ADDR_UPPER         = 4'h4;
  localparam logic [3:0]  ADDR_LOWER         = 4'h5;
  localparam logic [3:0]  ADDR_MON_CTRL      = 4'h6;
  localparam logic [3:0]  ADDR_INT_STATUS    = 4'h7;
  localparam logic [3:0]  ADDR_INT_ENABLE    = 4'h8;
  localparam int          GC_ENABLE_BIT      = 0;
  localparam int          GC_DELAY_LSB       = 1;
  localparam int          GC_DELAY_W         = 6;
  localparam int          MC_ENABLE_BIT      = 0;
  localparam int          MC_FUNC_LSB        = 1;
  localparam int          MC_COR_BIT         = 3;
  localparam int          MC_NOTIMER_BIT     = 4;
  localparam int          INT_MON_BIT        = 2;
  localparam logic [7:0]  GAIN_CTRL_RESET    = 8'h00;
  localparam logic [19:0] DWELL_RESET        = 20'h00000;
  localparam logic [23:0] PERIOD_RESET       = 24'h000000;
  localparam logic [9:0]  UPPER_RESET        = 10'h000;
  localparam logic [9:0]  LOWER_RESET        = 10'h000;
  localparam logic [4:0]  MON_CTRL_RESET     = 5'h00;
  localparam int          MEAN_SHIFT         = 4;
  typedef enum logic [1:0] {MODE_PEAK, MODE_MEAN, MODE_CROSS, MODE_BAD} igm_mode_e;
endpackage

/* File: igm_mon_if.sv */
// Interface carrying monitor controls and results between the top and the power monitor.
`timescale 1ns/10ps
`default_nettype none
interface igm_mon_if;
  logic        enable;
  logic [1:0]  func;
  logic        no_timer;
  logic        clr_on_read;
  logic [23:0] period;
  logic [9:0]  upper;
  logic        result_read;
  logic [23:0] result;
  logic        period_end;
  modport top (output enable, func, no_timer, clr_on_read, period, upper, result_read,
               input result, period_end);
  modport mon (input enable, func, no_timer, clr_on_read, period, upper, result_read,
               output result, period_end);
endinterface
`default_nettype wire

/* File: igm_power_monitor.sv */
// Power monitor: peak, mean power and threshold crossing measurement with holding register.
`timescale 1ns/10ps
`default_nettype none
module igm_power_monitor
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Sample magnitude
  input  wire logic [12:0] mag_i,
  // Control and results
  igm_mon_if.mon    mon
);
  logic [23:0] timer_reg;
  logic [23:0] acc_reg;
  logic [23:0] result_reg;
  logic        end_reg;
  logic [23:0] acc_next;
  logic [23:0] power;
  wire         timer_done = (timer_reg + 24'h000001 >= mon.period);
  wire         take_timer = mon.enable && !mon.no_timer && timer_done;
  wire         take_read  = mon.enable && mon.no_timer && mon.result_read;
  wire         take       = take_timer || take_read;
  wire         restart    = take_timer || (take_read && mon.clr_on_read);
  wire         above      = {1'b0, mag_i[12:3]} > {1'b0, mon.upper};

  assign power = 24'((26'(mag_i) * 26'(mag_i)) >> 2) >> igm_pkg::MEAN_SHIFT;

  always_comb
  begin
    acc_next = acc_reg;
    case (igm_pkg::igm_mode_e'(mon.func))
      igm_pkg::MODE_PEAK:  if (above && {11'h000, mag_i} > acc_reg) acc_next = {11'h000, mag_i};
      igm_pkg::MODE_MEAN:  acc_next = acc_reg - (acc_reg >> igm_pkg::MEAN_SHIFT) + power;
      igm_pkg::MODE_CROSS: if (above && acc_reg != 24'hFFFFFF) acc_next = acc_reg + 24'h000001;
      default:             acc_next = acc_reg;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer_reg  <= 24'h000000;
      acc_reg    <= 24'h000000;
      result_reg <= 24'h000000;
      end_reg    <= 1'b0;
    end
    else if (ce_i)
    begin
      end_reg <= take_timer;
      if (!mon.enable)
      begin
        timer_reg <= 24'h000000;
        acc_reg   <= 24'h000000;
      end
      else
      begin
        timer_reg <= take_timer ? 24'h000000 : timer_reg + 24'h000001;
        acc_reg   <= restart ? 24'h000000 : acc_next;
        if (take)
          result_reg <= acc_next;
      end
    end
  end

  assign mon.result     = result_reg;
  assign mon.period_end = end_reg;
endmodule
`default_nettype wire

/* File: igm_top.sv */
// Top of the input gain control and power monitor block with its register port.
// Summary of operation
// - Relinearization is applied one cycle more than a programmable 6-bit count of cycles after exponent drive.
// - Gain enable set drives exponent lines out; clear makes them inputs.
// - Sample magnitude above upper threshold changes gain while gain control active.
// - Sample magnitude below lower threshold starts the dwell counter.
// - The 20-bit dwell counter starts only after a drop below lower threshold.
// - Peak and crossing monitor modes use the shared upper threshold.
// - Monitor period counts ADC port clock cycles per interval.
// - Enabled monitor loads its result register at every period end.
// - With timer disabled, each software read updates the holding register.
// - Clear-on-read clears monitoring after a read, only when timer disabled.
// - Function 00 peak, 01 mean, 10 crossing; 11 is invalid.
// - Monitor enable runs the monitor; control bits reset to zero.
// - Period expiry sets monitor interrupt status only when its enable is set.
`timescale 1ns/10ps
`default_nettype none
module igm_top
#(
  parameter int SAMPLE_W = 14
)
(
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // Register port
  input  wire logic [3:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  // ADC samples and gain exponent lines
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic [2:0]          gain_exponent_lines_i,
  output logic      [2:0]          gain_exponent_lines_o,
  output logic      [2:0]          gain_exponent_lines_oe_o,
  // Relinearization exponent applied internally
  output logic      [2:0]          relin_exp_o,
  output logic                     mon_int_status_o
);
  igm_mon_if mon ();

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  gain_ctrl_reg;
  logic [19:0] dwell_reg;
  logic [23:0] period_reg;
  logic [9:0]  upper_reg;
  logic [9:0]  lower_reg;
  logic [4:0]  mon_ctrl_reg;
  logic        int_en_reg;
  logic        int_stat_reg;
  logic [31:0] rdata_reg;
  logic [2:0]  exp_reg;
  logic [2:0]  oe_reg;
  logic [19:0] dwell_cnt_reg;
  logic        dwell_run_reg;
  logic [2:0]  relin_reg;
  logic [2:0]  pipe_reg [0:63];
  logic [31:0] rd_mux;

  function automatic logic [12:0] abs_mag(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
    return 13'(a);
  endfunction

  wire [12:0] mag       = abs_mag(sample_i);
  wire [9:0]  mag_hi    = mag[12:3];
  wire        gc_on     = gain_ctrl_reg[igm_pkg::GC_ENABLE_BIT];
  wire [5:0]  pipe_dly  = gain_ctrl_reg[igm_pkg::GC_DELAY_LSB +: igm_pkg::GC_DELAY_W];
  wire        over_hi   = mag_hi > upper_reg;
  wire        under_lo  = mag_hi < lower_reg;
  wire        dwell_done = dwell_run_reg && (dwell_cnt_reg + 20'h00001 >= dwell_reg);
  wire        w_en      = wr_i && ce_i;
  wire        res_read  = rd_i && (addr_i == igm_pkg::ADDR_RESULT);
  wire        stat_clr  = w_en && (addr_i == igm_pkg::ADDR_INT_STATUS) && wdata_i[igm_pkg::INT_MON_BIT];
  wire [2:0]  exp_src   = gc_on ? exp_reg : gain_exponent_lines_i;
  wire [2:0]  relin_src = (pipe_dly == 6'h00) ? exp_src : pipe_reg[pipe_dly - 6'h01];

  assign mon.enable      = mon_ctrl_reg[igm_pkg::MC_ENABLE_BIT];
  assign mon.func        = mon_ctrl_reg[igm_pkg::MC_FUNC_LSB +: 2];
  assign mon.no_timer    = mon_ctrl_reg[igm_pkg::MC_NOTIMER_BIT];
  assign mon.clr_on_read = mon_ctrl_reg[igm_pkg::MC_COR_BIT] && mon_ctrl_reg[igm_pkg::MC_NOTIMER_BIT];
  assign mon.period      = period_reg;
  assign mon.upper       = upper_reg;
  assign mon.result_read = res_read;

  assign rd_mux = (addr_i == igm_pkg::ADDR_GAIN_CTRL)  ? {24'h000000, 1'b0, gain_ctrl_reg[6:0]} :
                  (addr_i == igm_pkg::ADDR_DWELL)      ? {12'h000, dwell_reg} :
                  (addr_i == igm_pkg::ADDR_PERIOD)     ? {8'h00, period_reg} :
                  (addr_i == igm_pkg::ADDR_RESULT)     ? {8'h00, mon.result} :
                  (addr_i == igm_pkg::ADDR_UPPER)      ? {22'h000000, upper_reg} :
                  (addr_i == igm_pkg::ADDR_LOWER)      ? {22'h000000, lower_reg} :
                  (addr_i == igm_pkg::ADDR_MON_CTRL)   ? {27'h0000000, mon_ctrl_reg} :
                  (addr_i == igm_pkg::ADDR_INT_STATUS) ? {29'h00000000, int_stat_reg, 2'b00} :
                  (addr_i == igm_pkg::ADDR_INT_ENABLE) ? {29'h00000000, int_en_reg, 2'b00} :
                  32'h00000000;

  igm_power_monitor u_mon
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .mag_i   (mag),
    .mon     (mon)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and read data.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gain_ctrl_reg <= igm_pkg::GAIN_CTRL_RESET;
      dwell_reg     <= igm_pkg::DWELL_RESET;
      period_reg    <= igm_pkg::PERIOD_RESET;
      upper_reg     <= igm_pkg::UPPER_RESET;
      lower_reg     <= igm_pkg::LOWER_RESET;
      mon_ctrl_reg  <= igm_pkg::MON_CTRL_RESET;
      int_en_reg    <= 1'b0;
      int_stat_reg  <= 1'b0;
      rdata_reg     <= 32'h00000000;
    end
    else if (ce_i)
    begin
      rdata_reg <= rd_i ? rd_mux : 32'h00000000;
      if (w_en)
        case (addr_i)
          igm_pkg::ADDR_GAIN_CTRL:  gain_ctrl_reg <= {1'b0, wdata_i[6:0]};
          igm_pkg::ADDR_DWELL:      dwell_reg     <= wdata_i[19:0];
          igm_pkg::ADDR_PERIOD:     period_reg    <= wdata_i[23:0];
          igm_pkg::ADDR_UPPER:      upper_reg     <= wdata_i[9:0];
          igm_pkg::ADDR_LOWER:      lower_reg     <= wdata_i[9:0];
          igm_pkg::ADDR_MON_CTRL:   mon_ctrl_reg  <= wdata_i[4:0];
          igm_pkg::ADDR_INT_ENABLE: int_en_reg    <= wdata_i[igm_pkg::INT_MON_BIT];
          default:                  ;
        endcase
      // A period end with the interrupt enable set, in the same cycle as a clear, keeps the flag set.
      if (mon.period_end && int_en_reg)
        int_stat_reg <= 1'b1;
      else if (stat_clr)
        int_stat_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gain control: fast attack above the upper limit, slow release after dwell.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      exp_reg       <= 3'h0;
      oe_reg        <= 3'h0;
      dwell_cnt_reg <= 20'h00000;
      dwell_run_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      oe_reg <= {3{gc_on}};
      if (!gc_on)
      begin
        dwell_run_reg <= 1'b0;
        dwell_cnt_reg <= 20'h00000;
      end
      else if (over_hi)
      begin
        if (exp_reg != 3'h7)
          exp_reg <= exp_reg + 3'h1;
        dwell_run_reg <= 1'b0;
        dwell_cnt_reg <= 20'h00000;
      end
      else if (!dwell_run_reg)
      begin
        dwell_run_reg <= under_lo;
        dwell_cnt_reg <= 20'h00000;
      end
      else if (!under_lo)
      begin
        dwell_run_reg <= 1'b0;
        dwell_cnt_reg <= 20'h00000;
      end
      else if (dwell_done)
      begin
        if (exp_reg != 3'h0)
          exp_reg <= exp_reg - 3'h1;
        dwell_run_reg <= 1'b0;
        dwell_cnt_reg <= 20'h00000;
      end
      else
        dwell_cnt_reg <= dwell_cnt_reg + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Relinearization delay line; long enough for the largest pipe delay.
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      pipe_reg[0] <= exp_src;
      for (int i = 1; i < 64; i++)
        pipe_reg[i] <= pipe_reg[i-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      relin_reg <= 3'h0;
    else if (ce_i)
      relin_reg <= relin_src;
  end

  assign rdata_o                  = rdata_reg;
  assign gain_exponent_lines_o    = exp_reg;
  assign gain_exponent_lines_oe_o = oe_reg;
  assign relin_exp_o              = relin_reg;
  assign mon_int_status_o         = int_stat_reg;
endmodule
`default_nettype wire

/* File: igm_adc_model.sv */
// External gain stage and ADC sample source facing the gain exponent pins.
`timescale 1ns/10ps
`default_nettype none
module igm_adc_model
(
  input  wire logic        clk_i,
  input  wire logic [12:0] amp_i,
  input  wire logic [2:0]  ext_exp_i,
  input  wire logic [2:0]  dev_exp_i,
  input  wire logic [2:0]  dev_oe_i,
  output logic      [13:0] sample_o,
  output logic      [2:0]  pin_exp_o
);
  logic [12:0] mag;
  // Each pin carries the device value while enabled, else the outside source.
  assign pin_exp_o = (dev_exp_i & dev_oe_i) | (ext_exp_i & ~dev_oe_i);
  assign mag = amp_i >> pin_exp_o;
  // A random sign makes the magnitude path see both polarities.
  initial sample_o = 14'h0000;
  always @(posedge clk_i)
    sample_o <= ($urandom_range(1) == 0) ? {1'b0, mag} : -{1'b0, mag};
endmodule
`default_nettype wire

/* File: igm_top_assertions.sv */
// Port checks for the input gain and power monitor top.
`timescale 1ns/10ps
`default_nettype none
module igm_top_assertions
#(
  parameter int SAMPLE_W = 14
)
(
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                ce_i,
  input wire logic [3:0]          addr_i,
  input wire logic [31:0]         wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic [2:0]          gain_exponent_lines_i,
  input wire logic [2:0]          gain_exponent_lines_o,
  input wire logic [2:0]          gain_exponent_lines_oe_o,
  input wire logic [2:0]          relin_exp_o,
  input wire logic                mon_int_status_o
);
  logic        gc_en;
  logic [5:0]  pipe;
  logic [9:0]  upper;
  logic        int_en;
  logic [3:0]  age;
  logic        wr_gc;
  logic [12:0] mag;
  logic [2:0]  gx;
  assign wr_gc = wr_i && ce_i && addr_i == igm_pkg::ADDR_GAIN_CTRL;
  assign mag = sample_i[SAMPLE_W-1] ? 13'(-sample_i) : 13'(sample_i);
  assign gx = gain_exponent_lines_o;
  // Shadows of the control fields, so the checks need no view inside.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {pipe, gc_en} <= 7'h00;
      upper <= 10'h000;
      int_en <= 1'b0;
      age <= 4'hF;
    end
    else
    begin
      age <= wr_gc ? 4'h0 : age + {3'h0, age != 4'hF};
      if (wr_gc) {pipe, gc_en} <= wdata_i[6:0];
      if (wr_i && ce_i && addr_i == igm_pkg::ADDR_UPPER) upper <= wdata_i[9:0];
      if (wr_i && ce_i && addr_i == igm_pkg::ADDR_INT_ENABLE) int_en <= wdata_i[2];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_over_at_zero;
    gc_en && mag[12:3] > upper && gx == 3'h0;
  endsequence
  sequence s_int_quiet;
    !int_en && !$past(int_en) && !$past(int_en, 2);
  endsequence
  a_oe_follows_enable: assert property (age > 4'h1 |-> gain_exponent_lines_oe_o == {3{gc_en}})
    else $error("exponent enables differ from gain enable");
  a_gain_rises_over: assert property (not (s_over_at_zero [*4]))
    else $error("exponent stays zero above upper limit");
  a_gain_step_one: assert property (gc_en && $past(gc_en) |-> (gx - $past(gx)) inside {3'h0, 3'h1, 3'h7})
    else $error("exponent moved by more than one");
  a_gain_holds_max: assert property (gc_en && $past(gc_en) && $past(gx) == 3'h7 |-> gx >= 3'h6)
    else $error("exponent wrapped past seven");
  a_relin_pipe_three: assert property (age == 4'hF && gc_en && pipe == 6'h03 |-> relin_exp_o == $past(gx, 4))
    else $error("relinearization delay wrong");
  a_relin_from_pins: assert property (age == 4'hF && !gc_en && pipe == 6'h00 |-> relin_exp_o == $past(gain_exponent_lines_i))
    else $error("relinearization not from input pins");
  a_int_needs_enable: assert property ($rose(mon_int_status_o) |-> $past(int_en) || $past(int_en, 2))
    else $error("status set while disabled");
  a_int_write_clear: assert property (s_int_quiet ##0 (wr_i && ce_i && addr_i == igm_pkg::ADDR_INT_STATUS && wdata_i[2]) |=> !mon_int_status_o)
    else $error("status not cleared by write");
endmodule
`default_nettype wire

/* File: igm_top_bench.sv */
// Self-checking bench for the input gain and power monitor top.
`timescale 1ns/10ps
`default_nettype none
module igm_top_bench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [13:0] sample_i;
  logic [2:0] gain_exponent_lines_i, gain_exponent_lines_o, gain_exponent_lines_oe_o, relin_exp_o;
  logic mon_int_status_o;
  logic [12:0] amp = 13'h0000;
  logic [2:0] ext = 3'h0;
  logic [32:0] expq [$];
  logic [32:0] e;
  logic [3:0] ra [4] = '{igm_pkg::ADDR_DWELL, igm_pkg::ADDR_PERIOD, igm_pkg::ADDR_UPPER, igm_pkg::ADDR_LOWER};
  logic [31:0] rm [4] = '{32'hFFFFF, 32'hFFFFFF, 32'h3FF, 32'h3FF};
  int n_errors = 0, checks = 0, cycles = 0;
  igm_top #(.SAMPLE_W(14)) igm_top_inst (.*);
  igm_adc_model igm_adc_model_inst (.clk_i(clk_i), .amp_i(amp), .ext_exp_i(ext), .dev_exp_i(gain_exponent_lines_o),
    .dev_oe_i(gain_exponent_lines_oe_o), .sample_o(sample_i), .pin_exp_o(gain_exponent_lines_i));
  initial forever #50 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checks = checks + 1;
    if (seen !== want)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic [3:0] a, input logic [31:0] v, input logic rd, input logic skip);
    if (rd) expq.push_back({skip, v});
    addr_i <= a;
    wdata_i <= v;
    rd_i <= rd;
    wr_i <= !rd;
    tick(1);
    {rd_i, wr_i} <= 2'h0;
    tick(1);
  endtask
  // Reads are compared when their data stands, one cycle after the strobe.
  always @(posedge clk_i)
  begin
    rd_seen <= rd_i;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  always @(negedge clk_i)
  begin
    if (rd_seen)
    begin
      e = expq.pop_front();
      if (!e[32]) check("rdata", rdata_o, e[31:0]);
    end
  end
  initial
  begin
    void'($urandom(32'hC792));
    tick(10);
    rst_n_i <= 1'b1;
    tick(1);
    for (int a = 0; a < 10; a++) bus(4'(a), 32'h0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom();
      bus(ra[i], d, 1'b0, 1'b0);
      bus(ra[i], d & rm[i], 1'b1, 1'b0);
    end
    bus(igm_pkg::ADDR_RESULT, 32'hFFFFFFFF, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_RESULT, 32'h0, 1'b1, 1'b0);
    bus(igm_pkg::ADDR_UPPER, 32'h0, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_LOWER, 32'h0, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_DWELL, 32'h5, 1'b0, 1'b0);
    amp <= 13'h1FFF;
    bus(igm_pkg::ADDR_GAIN_CTRL, 32'h7, 1'b0, 1'b0);
    tick(40);
    @(negedge clk_i);
    check("exp", {29'h0, gain_exponent_lines_o}, 32'h7);
    check("oe", {29'h0, gain_exponent_lines_oe_o}, 32'h7);
    check("relin", {29'h0, relin_exp_o}, 32'h7);
    tick(1);
    bus(igm_pkg::ADDR_UPPER, 32'h64, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_LOWER, 32'h14, 1'b0, 1'b0);
    tick(200);
    @(negedge clk_i);
    check("exp", {29'h0, gain_exponent_lines_o}, 32'h5);
    tick(1);
    amp <= 13'h12C;
    tick(200);
    @(negedge clk_i);
    check("exp", {29'h0, gain_exponent_lines_o}, 32'h0);
    tick(1);
    ext <= 3'h5;
    bus(igm_pkg::ADDR_GAIN_CTRL, 32'h0, 1'b0, 1'b0);
    tick(10);
    @(negedge clk_i);
    check("oe", {29'h0, gain_exponent_lines_oe_o}, 32'h0);
    check("relin", {29'h0, relin_exp_o}, 32'h5);
    tick(1);
    ce_i <= 1'b0;
    bus(igm_pkg::ADDR_LOWER, 32'h3FF, 1'b0, 1'b0);
    ce_i <= 1'b1;
    bus(igm_pkg::ADDR_LOWER, 32'h14, 1'b1, 1'b0);
    ext <= 3'h0;
    bus(igm_pkg::ADDR_PERIOD, 32'h8, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_INT_ENABLE, 32'h4, 1'b0, 1'b0);
    for (int m = 0; m < 3; m++)
    begin
      amp <= (m == 1) ? 13'h10 : 13'h7D0;
      bus(igm_pkg::ADDR_MON_CTRL, {29'h0, 2'(m), 1'b1}, 1'b0, 1'b0);
      tick(30);
      bus(igm_pkg::ADDR_RESULT, (m == 0) ? 32'h7D0 : (m == 1) ? 32'h1C : 32'h8, 1'b1, 1'b0);
    end
    @(negedge clk_i);
    check("status", {31'h0, mon_int_status_o}, 32'h1);
    tick(1);
    bus(igm_pkg::ADDR_INT_ENABLE, 32'h0, 1'b0, 1'b0);
    tick(3);
    bus(igm_pkg::ADDR_INT_STATUS, 32'h4, 1'b0, 1'b0);
    tick(30);
    @(negedge clk_i);
    check("status", {31'h0, mon_int_status_o}, 32'h0);
    tick(1);
    amp <= 13'hBB8;
    bus(igm_pkg::ADDR_MON_CTRL, 32'h19, 1'b0, 1'b0);
    bus(igm_pkg::ADDR_RESULT, 32'h0, 1'b1, 1'b1);
    tick(20);
    amp <= 13'h3E8;
    tick(1);
    bus(igm_pkg::ADDR_RESULT, 32'h0, 1'b1, 1'b1);
    tick(40);
    bus(igm_pkg::ADDR_RESULT, 32'hBB8, 1'b1, 1'b0);
    bus(igm_pkg::ADDR_RESULT, 32'h3E8, 1'b1, 1'b0);
    complete_run();
  end
endmodule
bind igm_top igm_top_assertions #(.SAMPLE_W(SAMPLE_W)) igm_top_assertions_inst (.*);
`default_nettype wire
